// ==== src/plc_cfg.svh ====
// Offsets, field positions, reset values and counts for the link registers.
// Assumes inclusion by the package and by the register bank only.
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH

`define PLC_OFS_LINK       8'hD0
`define PLC_OFS_IRQ_STAT   8'hE0
`define PLC_OFS_IRQ_MASK   8'hE4
`define PLC_OFS_SLOT_OVR   8'hE8

`define PLC_CTL_ASPM_LO    0
`define PLC_CTL_ASPM_HI    1
`define PLC_CTL_RCB        3
`define PLC_CTL_LDIS       4
`define PLC_CTL_RETRAIN    5
`define PLC_CTL_CCLK       6
`define PLC_CTL_EXTSYNC    7
`define PLC_CTL_HAWD       9
`define PLC_CTL_B10        10
`define PLC_CTL_B11        11
`define PLC_CTL_RW_MASK    16'h0EF3

`define PLC_STS_SPEED_LO   16
`define PLC_STS_SPEED_HI   19
`define PLC_STS_WIDTH_LO   20
`define PLC_STS_WIDTH_HI   25
`define PLC_STS_TERR       26
`define PLC_STS_LTRAIN     27
`define PLC_STS_SLOT_CLOCK_STRAP    28
`define PLC_STS_DLACT      29

`define PLC_RST_SPEED      4'h2
`define PLC_RST_WIDTH      6'h01
`define PLC_SPEED_2G5      4'h1
`define PLC_SPEED_5G0      4'h2

`define PLC_EXT_FTS        16'h1000
`define PLC_EXT_TS1        16'h0400
`define PLC_STRAP_SETTLE   2'h2

`define PLC_EVT_TERR       0
`define PLC_EVT_TDONE      1
`define PLC_EVT_DLCHG      2
`define PLC_EVT_W          3

`endif

// ==== src/plc_pkg.sv ====
// Types shared by the link control and status register bank.
// Assumes the constants header is on the include path.
`include "plc_cfg.svh"

package plc_pkg;

  typedef enum logic [1:0]
  {
    PLC_ASPM_OFF,
    PLC_ASPM_L0S,
    PLC_ASPM_L1,
    PLC_ASPM_BOTH
  } plc_aspm_t;

  typedef enum logic [1:0]
  {
    PLC_RESP_OKAY   = 2'h0,
    PLC_RESP_SLVERR = 2'h2
  } plc_resp_t;

endpackage : plc_pkg

// ==== src/plc_link_regs.sv ====
// Link control and link status register pair of one switch port.
// Assumes an AXI4-Lite master on clk_sys and same-clock training logic.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "plc_cfg.svh"

// How it works
// - ASPM field selects L0s/L1 entry, resets zero
// - Receiver may always enter L0s
// - Completion boundary bit reads zero always
// - Link disable: upstream zero, downstream disables
// - Retrain: upstream zero, downstream starts retraining
// - Retrain bit always reads zero
// - Common clock bit read-write, resets zero
// - Extended synch: 4096 FTS, 1024 TS1
// - Bits ten, eleven writable downstream only
// - Speed field reports speed, resets two
// - Width field reports width, resets one
// - Training error set on error, cleared in L0
// - Training bit high while training runs
// - Slot clock bit from strap, overridable
// - Link active bit follows DL_Active state
module plc_link_regs
  import plc_pkg::*;
#(
  parameter bit          IS_UPSTREAM = 1'b0,
  parameter logic [15:0] NORMAL_FTS  = 16'h0080,
  parameter logic [15:0] NORMAL_TS1  = 16'h0010
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  phy_speed,
  input  wire logic [5:0]  phy_width,
  input  wire logic        phy_train_start,
  input  wire logic        phy_train_done,
  input  wire logic        phy_train_err,
  input  wire logic        dl_active_state,
  input  wire logic        slot_clock_strap,
  output logic             aspm_l0s_en,
  output logic             aspm_l1_en,
  output logic             rx_l0s_allowed,
  output logic             link_disable,
  output logic             retrain_start,
  output logic             common_clock,
  output logic             hw_auto_width_dis,
  output logic [1:0]       ctl_spare,
  output logic [15:0]      fts_count,
  output logic [15:0]      ts1_count,
  output logic             irq
);

  // Long counts must never fall below the normal ones
  if (NORMAL_FTS > `PLC_EXT_FTS || NORMAL_TS1 > `PLC_EXT_TS1)
  begin : g_bad_counts
    $error("plc_link_regs: normal counts exceed extended counts");
  end

  logic [15:0]          ctl_ff;
  logic [3:0]           speed_ff;
  logic [5:0]           width_ff;
  logic                 terr_ff;
  logic                 ltrain_ff;
  logic                 slot_clock_strap_ff;
  logic                 dlact_ff;
  logic                 strap_s1_ff;
  logic                 strap_s2_ff;
  logic [1:0]           strap_cnt_ff;
  logic [`PLC_EVT_W-1:0] irq_stat_ff;
  logic [`PLC_EVT_W-1:0] irq_mask_ff;
  logic [7:0]           awaddr_ff;
  logic                 aw_got_ff;
  logic [31:0]          wdata_ff;
  logic [3:0]           wstrb_ff;
  logic                 w_got_ff;
  logic                 rd_link_ff;
  logic                 wr_fire;
  logic                 wr_link;
  logic                 wr_known;
  logic [15:0]          ctl_wmask;
  logic [15:0]          nxt_ctl;
  logic [31:0]          rd_word;
  logic                 rd_known;
  logic [`PLC_EVT_W-1:0] evt;
  logic [`PLC_EVT_W-1:0] w1c;

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
  assign wr_fire       = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wr_link       = wr_fire && (awaddr_ff == `PLC_OFS_LINK);
  assign wr_known      = (awaddr_ff == `PLC_OFS_LINK)
                      || (awaddr_ff == `PLC_OFS_IRQ_STAT)
                      || (awaddr_ff == `PLC_OFS_IRQ_MASK)
                      || (awaddr_ff == `PLC_OFS_SLOT_OVR);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? PLC_RESP_OKAY : PLC_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control half: only the writable bits of the enabled byte lanes move
  always_comb
  begin
    ctl_wmask = `PLC_CTL_RW_MASK
              & {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    if (IS_UPSTREAM)
    begin
      ctl_wmask[`PLC_CTL_LDIS] = 1'b0;
      ctl_wmask[`PLC_CTL_B10]  = 1'b0;
      ctl_wmask[`PLC_CTL_B11]  = 1'b0;
    end
    ctl_wmask[`PLC_CTL_RETRAIN] = 1'b0;
    nxt_ctl = (ctl_ff & ~ctl_wmask) | (wdata_ff[15:0] & ctl_wmask);
  end

  // reserved and read-only bits kept zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctl_ff <= 16'h0000;
    end
    else if (wr_link)
    begin
      ctl_ff <= nxt_ctl;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      retrain_start <= 1'b0;
    end
    else
    begin
      retrain_start <= wr_link && !IS_UPSTREAM && wstrb_ff[0]
                    && wdata_ff[`PLC_CTL_RETRAIN];
    end
  end

  assign aspm_l0s_en = (plc_aspm_t'(ctl_ff[1:0]) == PLC_ASPM_L0S)
                    || (plc_aspm_t'(ctl_ff[1:0]) == PLC_ASPM_BOTH);
  assign aspm_l1_en  = (plc_aspm_t'(ctl_ff[1:0]) == PLC_ASPM_L1)
                    || (plc_aspm_t'(ctl_ff[1:0]) == PLC_ASPM_BOTH);
  assign rx_l0s_allowed    = 1'b1;
  assign link_disable      = ctl_ff[`PLC_CTL_LDIS];
  assign common_clock      = ctl_ff[`PLC_CTL_CCLK];
  assign hw_auto_width_dis = ctl_ff[`PLC_CTL_HAWD];
  assign ctl_spare         = ctl_ff[`PLC_CTL_B11:`PLC_CTL_B10];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fts_count <= NORMAL_FTS;
      ts1_count <= NORMAL_TS1;
    end
    else
    begin
      fts_count <= ctl_ff[`PLC_CTL_EXTSYNC] ? `PLC_EXT_FTS : NORMAL_FTS;
      ts1_count <= ctl_ff[`PLC_CTL_EXTSYNC] ? `PLC_EXT_TS1 : NORMAL_TS1;
    end
  end

  // speed and width latched at each trained link
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      speed_ff <= `PLC_RST_SPEED;
      width_ff <= `PLC_RST_WIDTH;
    end
    else if (phy_train_done)
    begin
      speed_ff <= phy_speed;
      width_ff <= phy_width;
    end
  end

  // error set wins over the L0 clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      terr_ff <= 1'b0;
    end
    else if (phy_train_err)
    begin
      terr_ff <= 1'b1;
    end
    else if (phy_train_done)
    begin
      terr_ff <= 1'b0;
    end
  end

  // training flag, start wins over done
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ltrain_ff <= 1'b0;
    end
    else if (phy_train_start || retrain_start)
    begin
      ltrain_ff <= 1'b1;
    end
    else if (phy_train_done)
    begin
      ltrain_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dlact_ff <= 1'b0;
    end
    else
    begin
      dlact_ff <= dl_active_state;
    end
  end

  // Strap is an asynchronous pin
  always_ff @(posedge clk_sys)
  begin
    strap_s1_ff <= slot_clock_strap;
    strap_s2_ff <= strap_s1_ff;
  end

  // strap caught once synchroniser settles after release
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      strap_cnt_ff <= 2'h0;
      slot_clock_strap_ff   <= 1'b0;
    end
    else
    begin
      if (strap_cnt_ff != `PLC_STRAP_SETTLE)
      begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
      if (wr_fire && awaddr_ff == `PLC_OFS_SLOT_OVR && wstrb_ff[0]
          && wdata_ff[1])
      begin
        slot_clock_strap_ff <= wdata_ff[0];
      end
      else if (strap_cnt_ff == `PLC_STRAP_SETTLE - 2'h1)
      begin
        slot_clock_strap_ff <= strap_s2_ff;
      end
    end
  end

  // Interrupt events, set wins over write-one-clear
  assign evt[`PLC_EVT_TERR]  = phy_train_err && !terr_ff;
  assign evt[`PLC_EVT_TDONE] = phy_train_done;
  assign evt[`PLC_EVT_DLCHG] = dl_active_state != dlact_ff;
  assign w1c = (wr_fire && awaddr_ff == `PLC_OFS_IRQ_STAT && wstrb_ff[0])
             ? wdata_ff[`PLC_EVT_W-1:0] : '0;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_stat_ff <= '0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~w1c) | evt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_mask_ff <= '0;
    end
    else if (wr_fire && awaddr_ff == `PLC_OFS_IRQ_MASK && wstrb_ff[0])
    begin
      irq_mask_ff <= wdata_ff[`PLC_EVT_W-1:0];
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Read decode
  always_comb
  begin
    rd_word  = 32'h0000_0000;
    rd_known = 1'b1;
    if (s_axi_araddr == `PLC_OFS_LINK)
    begin
      // completion boundary and retrain read zero
      rd_word[15:0] = ctl_ff;
      rd_word[`PLC_STS_SPEED_HI:`PLC_STS_SPEED_LO] = speed_ff;
      rd_word[`PLC_STS_WIDTH_HI:`PLC_STS_WIDTH_LO] = width_ff;
      rd_word[`PLC_STS_TERR]    = terr_ff;
      rd_word[`PLC_STS_LTRAIN]  = ltrain_ff;
      rd_word[`PLC_STS_SLOT_CLOCK_STRAP] = slot_clock_strap_ff;
      rd_word[`PLC_STS_DLACT]   = dlact_ff;
    end
    else if (s_axi_araddr == `PLC_OFS_IRQ_STAT)
    begin
      rd_word[`PLC_EVT_W-1:0] = irq_stat_ff;
    end
    else if (s_axi_araddr == `PLC_OFS_IRQ_MASK)
    begin
      rd_word[`PLC_EVT_W-1:0] = irq_mask_ff;
    end
    else if (s_axi_araddr == `PLC_OFS_SLOT_OVR)
    begin
      rd_word[0] = slot_clock_strap_ff;
    end
    else
    begin
      rd_known = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
      rd_link_ff   <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? PLC_RESP_OKAY : PLC_RESP_SLVERR;
      rd_link_ff   <= s_axi_araddr == `PLC_OFS_LINK;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_retrain_req;
    retrain_start;
  endsequence

  sequence s_training_held;
    ltrain_ff[*2];
  endsequence

  a_aspm_decode: assert property (aspm_l0s_en == ctl_ff[0]
    && aspm_l1_en == ctl_ff[1])
    else $error("aspm enables disagree with field");

  a_rx_l0s_on: assert property (ctl_ff[1:0] == 2'h0
    |-> rx_l0s_allowed)
    else $error("receiver L0s blocked");

  a_rcb_reads_zero: assert property (s_axi_rvalid && rd_link_ff
    |-> !s_axi_rdata[`PLC_CTL_RCB])
    else $error("completion boundary bit read one");

  a_up_no_disable: assert property (IS_UPSTREAM
    |-> !link_disable && ctl_spare == 2'h0)
    else $error("upstream disable or spare bit set");

  a_retrain_trains: assert property (s_retrain_req
    |=> s_training_held or (ltrain_ff ##1 phy_train_done))
    else $error("retrain did not raise training");

  a_retrain_reads0: assert property (s_axi_rvalid && rd_link_ff
    |-> !s_axi_rdata[`PLC_CTL_RETRAIN])
    else $error("retrain bit read one");

  a_ext_sync_cnt: assert property (ctl_ff[`PLC_CTL_EXTSYNC]
    |=> fts_count == 16'h1000 && ts1_count == 16'h0400)
    else $error("extended synch counts wrong");

  a_terr_clear: assert property (phy_train_done && !phy_train_err
    |=> !terr_ff)
    else $error("training error not cleared");

  a_train_clear: assert property (phy_train_done && !phy_train_start
    && !retrain_start |=> !ltrain_ff)
    else $error("training bit not cleared");

  a_dl_active: assert property (
    ##1 dlact_ff == $past(dl_active_state))
    else $error("link active bit lags state");

  // speed reset value, checked through reset itself
  a_speed_reset: assert property (disable iff (1'b0)
    rst |=> speed_ff == 4'h2 && width_ff == 6'h01)
    else $error("speed or width reset wrong");

endmodule : plc_link_regs

`default_nettype wire

// ==== dv/plc_link_partner.sv ====
// Link partner model: answers a retrain pulse with one training run.
// Assumes the clk_sys domain; the bench steers outcome and duration.
`timescale 1ns/1ps
`default_nettype none
module plc_link_partner
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       retrain_start,
  input  wire logic       fail_next,
  input  wire logic [7:0] hold_cycles,
  input  wire logic [3:0] speed_sel,
  output logic      [3:0] phy_speed,
  output logic      [5:0] phy_width,
  output logic            phy_train_start,
  output logic            phy_train_done,
  output logic            phy_train_err,
  output logic            dl_active_state,
  output logic            busy_ff
);
  logic [7:0] cnt_ff;

  // Lanes carry junk outside the done pulse, never the last value
  always_ff @(posedge clk_sys)
  begin
    phy_train_start <= 1'h0;
    phy_train_done  <= 1'h0;
    phy_train_err   <= 1'h0;
    phy_speed       <= ~phy_speed;
    phy_width       <= ~phy_width;
    if (rst)
    begin
      busy_ff         <= 1'h0;
      cnt_ff          <= 8'h00;
      dl_active_state <= 1'h0;
      phy_speed       <= 4'h5;
      phy_width       <= 6'h2A;
    end
    else if (!busy_ff && retrain_start)
    begin
      busy_ff         <= 1'h1;
      cnt_ff          <= hold_cycles;
      phy_train_start <= 1'h1;
    end
    else if (busy_ff && cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
    else if (busy_ff)
    begin
      busy_ff <= 1'h0;
      if (fail_next)
        phy_train_err <= 1'h1;
      else
      begin
        phy_train_done  <= 1'h1;
        phy_speed       <= speed_sel;
        phy_width       <= 6'h01;
        dl_active_state <= 1'h1;
      end
    end
  end
endmodule : plc_link_partner
`default_nettype wire

// ==== dv/plc_link_regs_tb.sv ====
// Bench for the link register pair: AXI4-Lite master, partner, checks.
// Assumes the package, header, design and partner model are compiled.
`timescale 1ns/1ps
`default_nettype none
module plc_link_regs_tb
  import plc_pkg::*;
;
  localparam logic [7:0]  A_LINK = 8'hD0;
  localparam logic [7:0]  A_ST   = 8'hE0;
  localparam logic [7:0]  A_MK   = 8'hE4;
  localparam logic [7:0]  A_SL   = 8'hE8;
  localparam logic [31:0] ST_RST = 32'h1012_0000;
  logic        clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, strap, irq;
  logic [7:0]  awaddr, araddr, hold;
  logic [31:0] wdata, rdata, d, v, e, up_rdata;
  logic [3:0]  wstrb, phy_speed, speed_sel;
  logic [1:0]  bresp, rresp, r, ctl_spare, up_spare;
  logic [5:0]  phy_width;
  logic        t_start, t_done, t_err, dl_act, fail_next, p_busy;
  logic        l0s_en, l1_en, rx_l0s, ldis, rt_start, cclk, hawd;
  logic        up_ldis, up_rt;
  logic [15:0] fts, ts1, lfsr_ff;
  int          errors, n_compared, cyc, n_rt, n0, n_up_rt;

  plc_link_regs plc_link_regs_inst (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .phy_speed(phy_speed), .phy_width(phy_width),
    .phy_train_start(t_start), .phy_train_done(t_done),
    .phy_train_err(t_err), .dl_active_state(dl_act),
    .slot_clock_strap(strap), .aspm_l0s_en(l0s_en), .aspm_l1_en(l1_en),
    .rx_l0s_allowed(rx_l0s), .link_disable(ldis),
    .retrain_start(rt_start), .common_clock(cclk),
    .hw_auto_width_dis(hawd), .ctl_spare(ctl_spare), .fts_count(fts),
    .ts1_count(ts1), .irq(irq));

  plc_link_partner plc_link_partner_inst (.clk_sys(clk_sys), .rst(rst),
    .retrain_start(rt_start), .fail_next(fail_next), .hold_cycles(hold),
    .speed_sel(speed_sel), .phy_speed(phy_speed), .phy_width(phy_width),
    .phy_train_start(t_start), .phy_train_done(t_done),
    .phy_train_err(t_err), .dl_active_state(dl_act), .busy_ff(p_busy));

  // Upstream copy shares the bus; its control half, disable, spare and retrain outputs are compared
  plc_link_regs #(.IS_UPSTREAM(1'b1)) plc_link_regs_up_inst (
    .clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(up_rdata),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .phy_speed(phy_speed), .phy_width(phy_width),
    .phy_train_start(t_start), .phy_train_done(t_done),
    .phy_train_err(t_err), .dl_active_state(dl_act),
    .slot_clock_strap(strap), .aspm_l0s_en(), .aspm_l1_en(),
    .rx_l0s_allowed(), .link_disable(up_ldis), .retrain_start(up_rt),
    .common_clock(), .hw_auto_width_dis(), .ctl_spare(up_spare),
    .fts_count(), .ts1_count(), .irq());

  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [31:0] cnt_exp(input logic ext);
    return ext ? 32'h1000_0400 : 32'h0080_0010;
  endfunction : cnt_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task finish_test;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // Handshakes are judged mid-cycle, where every signal has settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dd,
                        input logic [3:0] s, output logic [1:0] rs);
    logic aw, w, b;
    int t;
    aw = 0;
    w = 0;
    b = 0;
    t = 0;
    awaddr <= a;
    wdata <= dd;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b && t < 200)
    begin
      @(negedge clk_sys);
      aw = awvalid && awready === 1'h1;
      w = wvalid && wready === 1'h1;
      b = bvalid === 1'h1;
      rs = bresp;
      @(posedge clk_sys);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      t++;
    end
    bready <= 1'h0;
    @(posedge clk_sys);
    if (!b) errors++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dd,
                        output logic [1:0] rs);
    logic ar, b;
    int t;
    ar = 0;
    b = 0;
    t = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!b && t < 200)
    begin
      @(negedge clk_sys);
      ar = arvalid && arready === 1'h1;
      b = rvalid === 1'h1;
      dd = rdata;
      rs = rresp;
      @(posedge clk_sys);
      if (ar) arvalid <= 1'h0;
      t++;
    end
    rready <= 1'h0;
    @(posedge clk_sys);
    if (!b) errors++;
  endtask : axi_rd

  task automatic retrain(input logic fail, input logic [3:0] spd);
    int t;
    t = 0;
    fail_next <= fail;
    speed_sel <= spd;
    n0 = n_rt;
    axi_wr(A_LINK, 32'h0000_0020, 4'hF, r);
    axi_rd(A_LINK, v, r);
    chk(v & 32'h0800_00FF, 32'h0800_0000);
    chk(n_rt - n0, 1);
    while (p_busy && t < 300)
    begin
      @(posedge clk_sys);
      t++;
    end
    repeat (3) @(posedge clk_sys);
  endtask : retrain

  always @(posedge clk_sys)
  begin
    cyc++;
    if (rt_start === 1'h1) n_rt++;
    if (up_rt === 1'h1) n_up_rt++;
    if (cyc == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  initial
  begin
    {rst, strap} = 2'h3;
    {awvalid, wvalid, bready, arvalid, rready, fail_next} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    hold = 8'h14;
    speed_sel = 4'h1;
    lfsr_ff = 16'h003D;
    {errors, n_compared, cyc, n_rt, n_up_rt} = 160'h0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'h0;
    // Slot clock bit only settles two edges after release
    repeat (3) @(posedge clk_sys);
    axi_rd(A_LINK, v, r);
    chk(v, ST_RST);
    for (int i = 0; i < 16; i++)
    begin
      lfsr_ff = lfsr_next(lfsr_ff);
      d = {lfsr_ff, lfsr_ff ^ 16'hA5C3} & 32'hFFFF_FFDF;
      d[1:0] = i[1:0];
      axi_wr(A_LINK, d, 4'hF, r);
      chk({30'h0, r}, 32'h0);
      axi_rd(A_LINK, v, r);
      chk(v, ST_RST | (d & 32'h0EF3));
      v = {up_rdata[15:0], 13'h0, up_ldis, up_spare};
      chk(v, {d[15:0] & 16'h02E3, 16'h0});
      v = {24'h0, l1_en, l0s_en, rx_l0s, ldis, cclk, hawd, ctl_spare};
      e = {24'h0, d[1:0], 1'h1, d[4], d[6], d[9], d[11:10]};
      chk(v, e);
      chk({fts, ts1}, cnt_exp(d[7]));
    end
    axi_wr(A_LINK, 32'h0000_00FF, 4'hE, r);
    axi_rd(A_LINK, v, r);
    chk(v, ST_RST | (d & 32'h00F3));
    axi_wr(A_LINK, 32'h0, 4'hF, r);
    retrain(1'h0, 4'h1);
    axi_rd(A_LINK, v, r);
    chk(v, 32'h3011_0000);
    axi_rd(A_ST, v, r);
    chk(v, 32'h6);
    chk({31'h0, irq}, 32'h0);
    axi_wr(A_MK, 32'h7, 4'hF, r);
    chk({31'h0, irq}, 32'h1);
    axi_wr(A_ST, 32'h7, 4'hF, r);
    axi_rd(A_ST, v, r);
    chk({v[2:0], 28'h0, irq}, 32'h0);
    hold <= 8'h02;
    // A failed run leaves training pending until a later success
    retrain(1'h1, 4'h2);
    axi_rd(A_LINK, v, r);
    chk(v, 32'h3C11_0000);
    axi_rd(A_ST, v, r);
    chk({v[2:0], 28'h0, irq}, 32'h2000_0001);
    axi_wr(A_ST, 32'h7, 4'hF, r);
    retrain(1'h0, 4'h2);
    axi_rd(A_LINK, v, r);
    chk(v, 32'h3012_0000);
    axi_wr(8'h40, 32'h1, 4'hF, r);
    chk({30'h0, r}, 32'h2);
    axi_rd(8'h44, v, r);
    chk({v[29:0], r}, 32'h2);
    axi_wr(A_SL, 32'h2, 4'hF, r);
    axi_rd(A_LINK, v, r);
    chk(v, 32'h2012_0000);
    axi_wr(A_SL, 32'h3, 4'hF, r);
    axi_rd(A_SL, v, r);
    chk(v & 32'h1, 32'h1);
    chk(n_up_rt, 0);
    finish_test();
  end
endmodule : plc_link_regs_tb
`default_nettype wire
